// file: rtl/ptca_regs.svh
// Register offsets, field positions, reset values and counts of the time clock
`ifndef PTCA_REGS_SVH
`define PTCA_REGS_SVH

// Register offsets, byte addresses of 16-bit words
`define PTCA_OFF_CTRL 16'h0500
`define PTCA_OFF_PHASE 16'h0502
`define PTCA_OFF_NS_HI 16'h0504
`define PTCA_OFF_NS_LO 16'h0506
`define PTCA_OFF_SEC_HI 16'h0508
`define PTCA_OFF_SEC_LO 16'h050A
`define PTCA_OFF_RATE_HI 16'h050C
`define PTCA_OFF_RATE_LO 16'h050E
`define PTCA_OFF_DUR_HI 16'h0510
`define PTCA_OFF_DUR_LO 16'h0512

// Control register bit positions
`define PTCA_CTRL_RESET 0
`define PTCA_CTRL_ENABLE 1
`define PTCA_CTRL_CONT 2
`define PTCA_CTRL_LOAD 3
`define PTCA_CTRL_READ 4
`define PTCA_CTRL_STEP_DIR 5
`define PTCA_CTRL_STEP 6
`define PTCA_CTRL_FREQ_OFF 15

// Rate high word bit positions
`define PTCA_RATE_DIR 15
`define PTCA_RATE_TEMP 14
`define PTCA_RATE_HI_MSB 13

// Reset values and counts
`define PTCA_RESET_WORD 16'h0000
`define PTCA_TICK_NS 32'd40
`define PTCA_NS_PER_SEC 32'd1000000000
`define PTCA_PHASE_MAX 3'h4

`endif

// file: rtl/ptca_pkg.sv
// Types shared by the time clock design files
package ptca_pkg;

    // One register access from the management side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } ptca_req_s;

    // Running time as seen outside
    typedef struct packed {
        logic [31:0] sec;
        logic [31:0] ns;
        logic [2:0] phase;
    } ptca_time_s;

    // Whole state of the time clock
    typedef struct packed {
        ptca_time_s now;
        logic [29:0] frac;
        logic enable;
        logic cont;
        logic step_dir;
        logic freq_off;
        ptca_time_s sw;
        logic rate_dir;
        logic temp;
        logic [29:0] rate;
        logic [31:0] dur;
        logic [31:0] left;
        logic [15:0] rdata;
        logic rvalid;
    } ptca_state_s;

endpackage

// file: rtl/ptca_time_add.sv
// Seconds and nanoseconds adder with wrap at one second
`timescale 1ns/1ps
`include "ptca_regs.svh"

module ptca_time_add
    import ptca_pkg::*;
(
    // Operands
    input wire logic [31:0] sec_in,
    input wire logic [31:0] ns_in,
    input wire logic [31:0] add_sec_in,
    input wire logic [31:0] add_ns_in,
    input wire logic sub_in,
    // Result
    output logic [31:0] sec_out,
    output logic [31:0] ns_out
);

    // Wide sum keeps the carry out of the nanosecond field
    logic [32:0] sum;

    // Nanoseconds assumed below one second on both operands
    always_comb begin
        sum = {1'b0, ns_in} + {1'b0, add_ns_in};
        if (sub_in) begin
            // Borrow one second when the nanoseconds go negative
            if (ns_in < add_ns_in) begin
                ns_out = ns_in + `PTCA_NS_PER_SEC - add_ns_in;
                sec_out = sec_in - add_sec_in - 32'h00000001;
            end else begin
                ns_out = ns_in - add_ns_in;
                sec_out = sec_in - add_sec_in;
            end
        end else if (sum >= {1'b0, `PTCA_NS_PER_SEC}) begin
            // Wrap and carry into seconds
            ns_out = sum[31:0] - `PTCA_NS_PER_SEC;
            sec_out = sec_in + add_sec_in + 32'h00000001;
        end else begin
            ns_out = sum[31:0];
            sec_out = sec_in + add_sec_in;
        end
    end

endmodule

// file: rtl/ptca_clock.sv
// PTP real time clock with load, read, step and rate trim
//
// Function
// RL1: continuous mode applies rate every cycle
// RL2: enable bit 1 runs or stops clock
// RL3: software enables clock before timestamp use
// RL4: reset bit 0 clears clock, self clears
// RL5: phase field gives 8 ns sub-phase
// RL6: software never writes phase codes above four
// RL7: nanoseconds held as two 16-bit words
// RL8: seconds held as two 16-bit words
// RL9: direction bit 15: one adds, zero subtracts
// RL10: temporary bit 14 trims for duration
// RL11: clearing temporary bit stops the trim
// RL12: rate is 30 bits over two words
// RL13: duration is 32-bit cycle count, two words
// RL14: read bit snapshots clock into time registers
// RL15: load bit copies time registers into clock
// RL16: step bit 6 adds or subtracts time
// RL17: clock advances 40 ns, wraps at second
// RL18: duration used up ends temporary trim
`timescale 1ns/1ps
`include "ptca_regs.svh"

module ptca_clock
    import ptca_pkg::*;
(
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // Register access port
    input wire ptca_req_s REG_REQ_IN,
    output logic [15:0] RD_DATA_OUT,
    output logic RD_VALID_OUT,
    // Running time and temporary trim status
    output ptca_time_s TIME_OUT,
    output logic ADJ_ACTIVE_OUT
);

    // Current and next state
    ptca_state_s s_r;
    ptca_state_s s_nxt;

    // Decoded writes of this cycle
    logic wr_ctrl;
    logic wr_rate_hi;
    // Fraction accumulator carry and borrow
    logic [30:0] frac_sum;
    logic [30:0] frac_diff;
    // Trim applies this cycle
    logic trim_on;
    // Nanoseconds added this tick
    logic [31:0] tick_ns;
    // Adder results for the tick and the step
    logic [31:0] tick_sec_res;
    logic [31:0] tick_ns_res;
    logic [31:0] step_sec_res;
    logic [31:0] step_ns_res;

    // Write decode
    assign wr_ctrl = REG_REQ_IN.wr && (REG_REQ_IN.addr == `PTCA_OFF_CTRL);
    assign wr_rate_hi = REG_REQ_IN.wr &&
        (REG_REQ_IN.addr == `PTCA_OFF_RATE_HI);

    // Per-tick increment with sub-nanosecond carry or borrow
    always_comb begin
        frac_sum = {1'b0, s_r.frac} + {1'b0, s_r.rate};
        frac_diff = {1'b0, s_r.frac} - {1'b0, s_r.rate};
        // RL10 temporary trim only while cycles remain
        trim_on = s_r.cont || (s_r.temp && (s_r.left != 32'h00000000));
        tick_ns = `PTCA_TICK_NS;
        if (trim_on) begin
            // RL9 direction picks carry in or borrow out
            if (s_r.rate_dir) begin
                tick_ns = `PTCA_TICK_NS + {31'h00000000, frac_sum[30]};
            end else begin
                tick_ns = `PTCA_TICK_NS - {31'h00000000, frac_diff[30]};
            end
        end
    end

    // RL17 per-tick advance, trim included, with wrap into seconds
    ptca_time_add u_tick (
        .sec_in(s_r.now.sec),
        .ns_in(s_r.now.ns),
        .add_sec_in(32'h00000000),
        .add_ns_in(tick_ns),
        .sub_in(1'b0),
        .sec_out(tick_sec_res),
        .ns_out(tick_ns_res)
    );

    // RL16 step by the held time, direction from the written word
    ptca_time_add u_step (
        .sec_in(s_r.now.sec),
        .ns_in(s_r.now.ns),
        .add_sec_in(s_r.sw.sec),
        .add_ns_in(s_r.sw.ns),
        .sub_in(!REG_REQ_IN.wdata[`PTCA_CTRL_STEP_DIR]),
        .sec_out(step_sec_res),
        .ns_out(step_ns_res)
    );

    // Next state: running clock first, then register effects on top
    always_comb begin
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;

        // RL2 clock only ticks while enabled
        if (s_r.enable) begin
            s_nxt.now.sec = tick_sec_res;
            s_nxt.now.ns = tick_ns_res;
            // RL1 fraction accumulates every cycle of trim
            if (trim_on) begin
                if (s_r.rate_dir) begin
                    s_nxt.frac = frac_sum[29:0];
                end else begin
                    s_nxt.frac = frac_diff[29:0];
                end
            end
            // Duration counts down only while trimming
            if (s_r.temp && (s_r.left != 32'h00000000)) begin
                s_nxt.left = s_r.left - 32'h00000001;
            end
        end

        // RL18 trim ends when the count is used up
        if (s_r.temp && (s_r.left <= 32'h00000001) &&
            (s_r.enable || (s_r.left == 32'h00000000))) begin
            s_nxt.temp = 1'b0;
            s_nxt.left = 32'h00000000;
        end

        // Register writes
        if (REG_REQ_IN.wr) begin
            unique case (REG_REQ_IN.addr)
                `PTCA_OFF_CTRL: begin
                    // Mode bits are stored, action bits are pulses
                    s_nxt.enable = REG_REQ_IN.wdata[`PTCA_CTRL_ENABLE];
                    s_nxt.cont = REG_REQ_IN.wdata[`PTCA_CTRL_CONT];
                    s_nxt.step_dir = REG_REQ_IN.wdata[`PTCA_CTRL_STEP_DIR];
                    s_nxt.freq_off = REG_REQ_IN.wdata[`PTCA_CTRL_FREQ_OFF];
                    // RL14 snapshot sees the value before this tick
                    if (REG_REQ_IN.wdata[`PTCA_CTRL_READ]) begin
                        s_nxt.sw = s_r.now;
                    end
                    // Reset wins over load, load over step
                    if (REG_REQ_IN.wdata[`PTCA_CTRL_RESET]) begin
                        // RL4 clear the whole running time
                        s_nxt.now = '0;
                        s_nxt.frac = 30'h00000000;
                    end else if (REG_REQ_IN.wdata[`PTCA_CTRL_LOAD]) begin
                        // RL15 running time replaced by held time
                        s_nxt.now = s_r.sw;
                        s_nxt.frac = 30'h00000000;
                    end else if (REG_REQ_IN.wdata[`PTCA_CTRL_STEP]) begin
                        // RL16 one-shot step, tick of this cycle dropped
                        s_nxt.now.sec = step_sec_res;
                        s_nxt.now.ns = step_ns_res;
                    end
                end
                // RL5 only the three phase bits are kept
                `PTCA_OFF_PHASE: s_nxt.sw.phase = REG_REQ_IN.wdata[2:0];
                // RL7 nanosecond halves
                `PTCA_OFF_NS_HI: s_nxt.sw.ns[31:16] = REG_REQ_IN.wdata;
                `PTCA_OFF_NS_LO: s_nxt.sw.ns[15:0] = REG_REQ_IN.wdata;
                // RL8 second halves
                `PTCA_OFF_SEC_HI: s_nxt.sw.sec[31:16] = REG_REQ_IN.wdata;
                `PTCA_OFF_SEC_LO: s_nxt.sw.sec[15:0] = REG_REQ_IN.wdata;
                `PTCA_OFF_RATE_HI: begin
                    s_nxt.rate_dir = REG_REQ_IN.wdata[`PTCA_RATE_DIR];
                    // RL12 upper rate bits
                    s_nxt.rate[29:16] =
                        REG_REQ_IN.wdata[`PTCA_RATE_HI_MSB:0];
                    s_nxt.temp = REG_REQ_IN.wdata[`PTCA_RATE_TEMP];
                    // RL11 clearing stops, setting restarts the count
                    if (REG_REQ_IN.wdata[`PTCA_RATE_TEMP]) begin
                        s_nxt.left = s_r.dur;
                    end else begin
                        s_nxt.left = 32'h00000000;
                    end
                end
                // RL12 lower rate bits
                `PTCA_OFF_RATE_LO: s_nxt.rate[15:0] = REG_REQ_IN.wdata;
                // RL13 duration halves
                `PTCA_OFF_DUR_HI: s_nxt.dur[31:16] = REG_REQ_IN.wdata;
                `PTCA_OFF_DUR_LO: s_nxt.dur[15:0] = REG_REQ_IN.wdata;
                // Unmapped writes are dropped
                default: s_nxt.rvalid = 1'b0;
            endcase
        end

        // Register reads, answered one cycle later
        if (REG_REQ_IN.rd) begin
            s_nxt.rvalid = 1'b1;
            unique case (REG_REQ_IN.addr)
                // Self-clearing action bits always read zero
                `PTCA_OFF_CTRL: s_nxt.rdata = {s_r.freq_off, 8'h00,
                    1'b0, s_r.step_dir, 2'h0, s_r.cont, s_r.enable, 1'b0};
                `PTCA_OFF_PHASE: s_nxt.rdata = {13'h0000, s_r.sw.phase};
                `PTCA_OFF_NS_HI: s_nxt.rdata = s_r.sw.ns[31:16];
                `PTCA_OFF_NS_LO: s_nxt.rdata = s_r.sw.ns[15:0];
                `PTCA_OFF_SEC_HI: s_nxt.rdata = s_r.sw.sec[31:16];
                `PTCA_OFF_SEC_LO: s_nxt.rdata = s_r.sw.sec[15:0];
                // Temporary bit reads back the live trim state
                `PTCA_OFF_RATE_HI: s_nxt.rdata = {s_r.rate_dir, s_r.temp,
                    s_r.rate[29:16]};
                `PTCA_OFF_RATE_LO: s_nxt.rdata = s_r.rate[15:0];
                `PTCA_OFF_DUR_HI: s_nxt.rdata = s_r.dur[31:16];
                `PTCA_OFF_DUR_LO: s_nxt.rdata = s_r.dur[15:0];
                // Unmapped reads answer zero
                default: s_nxt.rdata = `PTCA_RESET_WORD;
            endcase
        end
    end

    // State register, synchronous reset
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state flops
    assign RD_DATA_OUT = s_r.rdata;
    assign RD_VALID_OUT = s_r.rvalid;
    assign TIME_OUT = s_r.now;
    assign ADJ_ACTIVE_OUT = s_r.temp;

    // Checks, all on the one clock
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RST_IN);

    // Quiet cycle: no write that moves the clock
    logic quiet;
    assign quiet = !wr_ctrl && !wr_rate_hi;
    // Nanoseconds far from the wrap point
    logic ns_low;
    assign ns_low = s_r.now.ns < 32'd999000000;

    sequence plain_tick_s;
        quiet && s_r.enable && !trim_on && ns_low;
    endsequence
    sequence trim_tick_s(logic dir);
        quiet && s_r.enable && s_r.cont && (s_r.rate_dir == dir) && ns_low;
    endsequence

    plain_advance_a: assert property ( // RL17
        plain_tick_s |=> s_r.now.ns == $past(s_r.now.ns) + `PTCA_TICK_NS)
        else $error("Clock did not advance by 40 ns");
    trim_add_a: assert property ( // RL1
        trim_tick_s(1'b1) |=> (s_r.now.ns - $past(s_r.now.ns)) inside
            {32'd40, 32'd41})
        else $error("Additive trim gave a wrong step");
    trim_sub_a: assert property ( // RL9
        trim_tick_s(1'b0) |=> (s_r.now.ns - $past(s_r.now.ns)) inside
            {32'd39, 32'd40})
        else $error("Subtractive trim gave a wrong step");
    halt_clock_a: assert property ( // RL2
        !s_r.enable && quiet |=> $stable(s_r.now))
        else $error("Clock moved while disabled");
    reset_bit_a: assert property ( // RL4
        wr_ctrl && REG_REQ_IN.wdata[`PTCA_CTRL_RESET] |=>
            (s_r.now == '0) ##0 (s_r.frac == 30'h00000000))
        else $error("Reset bit did not clear the clock");
    read_snap_a: assert property ( // RL14
        wr_ctrl && REG_REQ_IN.wdata[`PTCA_CTRL_READ] |=>
            s_r.sw == $past(s_r.now))
        else $error("Snapshot does not match the clock");
    load_time_a: assert property ( // RL15
        wr_ctrl && REG_REQ_IN.wdata[`PTCA_CTRL_LOAD] &&
        !REG_REQ_IN.wdata[`PTCA_CTRL_RESET] |=> s_r.now == $past(s_r.sw))
        else $error("Load did not copy the held time");
    temp_end_a: assert property ( // RL18
        s_r.temp && s_r.enable && (s_r.left == 32'h00000001) &&
        !wr_rate_hi |=> !s_r.temp ##1 (!s_r.temp || $past(wr_rate_hi)))
        else $error("Trim did not end at count exhaustion");
    temp_stop_a: assert property ( // RL11
        wr_rate_hi && !REG_REQ_IN.wdata[`PTCA_RATE_TEMP] |=>
            !s_r.temp && (s_r.left == 32'h00000000))
        else $error("Clearing the trim bit did not stop it");
    ns_read_a: assert property ( // RL7
        REG_REQ_IN.rd && (REG_REQ_IN.addr == `PTCA_OFF_NS_HI) |=>
            RD_VALID_OUT && (RD_DATA_OUT == $past(s_r.sw.ns[31:16])))
        else $error("Nanosecond high word read back wrong");
    rate_read_a: assert property ( // RL12
        REG_REQ_IN.rd && (REG_REQ_IN.addr == `PTCA_OFF_RATE_LO) |=>
            RD_VALID_OUT && (RD_DATA_OUT == $past(s_r.rate[15:0])))
        else $error("Rate low word read back wrong");
    temp_count_a: assert property ( // RL10
        s_r.temp && s_r.enable && (s_r.left != 32'h00000000) &&
        !wr_rate_hi |=> s_r.left == $past(s_r.left) - 32'h00000001)
        else $error("Trim duration did not count down");
    // Forward step nanoseconds land on the sum, less one second if they wrapped; seconds are not checked
    step_add_a: assert property ( // RL16
        wr_ctrl && REG_REQ_IN.wdata[`PTCA_CTRL_STEP] &&
        REG_REQ_IN.wdata[`PTCA_CTRL_STEP_DIR] &&
        !REG_REQ_IN.wdata[`PTCA_CTRL_RESET] &&
        !REG_REQ_IN.wdata[`PTCA_CTRL_LOAD] |=>
        ((s_r.now.ns == $past(s_r.now.ns) + $past(s_r.sw.ns)) ||
         (s_r.now.ns + `PTCA_NS_PER_SEC ==
          $past(s_r.now.ns) + $past(s_r.sw.ns))))
        else $error("Forward step gave a wrong time");

endmodule

// file: sim/ptca_clock_bench.sv
// Self-checking bench for the time clock and its register port
`timescale 1ns/1ps
`include "ptca_regs.svh"

module ptca_clock_bench
    import ptca_pkg::*;
;
    // Bench clock and reset
    logic CLK_IN = 1'b0;
    logic RST_IN = 1'b1;
    // Register request driven by the bench
    ptca_req_s req = '0;
    // Design outputs
    logic [15:0] rd_data;
    logic rd_valid;
    ptca_time_s now;
    logic adj;
    // Counters and expected read data
    int mismatches = 0;
    int cmp_count = 0;
    logic [15:0] exp_q[$];
    ptca_time_s t0;
    logic [15:0] v;
    // Random held time for the load test
    logic [31:0] rs;
    logic [31:0] rn;

    // 20 MHz clock
    always #25 CLK_IN = ~CLK_IN;

    ptca_clock ptca_clock_inst (
        .CLK_IN(CLK_IN),
        .RST_IN(RST_IN),
        .REG_REQ_IN(req),
        .RD_DATA_OUT(rd_data),
        .RD_VALID_OUT(rd_valid),
        .TIME_OUT(now),
        .ADJ_ACTIVE_OUT(adj)
    );

    // Compare one value, wide enough for a whole time value
    task automatic chk(input string what, input logic [66:0] seen,
                       input logic [66:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One access; an idle cycle follows so the strobe never re-rises
    task automatic acc(input logic w, input logic r, input logic [15:0] a,
                       input logic [15:0] d);
        req = '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge CLK_IN);
        #1;
        req = '0;
        @(posedge CLK_IN);
        #1;
    endtask

    task automatic wrt(input logic [15:0] a, input logic [15:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask

    // Read; the monitor compares when the answer appears
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        acc(1'b0, 1'b1, a, 16'h0000);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_IN);
        #1;
    endtask

    // Held time words: phase, nanoseconds, seconds
    task automatic hold(input logic [31:0] s, input logic [31:0] n,
                        input logic [2:0] p);
        wrt(`PTCA_OFF_PHASE, {13'h0000, p});
        wrt(`PTCA_OFF_NS_HI, n[31:16]);
        wrt(`PTCA_OFF_NS_LO, n[15:0]);
        wrt(`PTCA_OFF_SEC_HI, s[31:16]);
        wrt(`PTCA_OFF_SEC_LO, s[15:0]);
    endtask

    // Expected time after adding d nanoseconds, wrapping at one second
    function automatic ptca_time_s tadd(input ptca_time_s t,
                                        input logic [31:0] d);
        logic [32:0] n;
        n = {1'b0, t.ns} + {1'b0, d};
        tadd = t;
        if (n >= {1'b0, `PTCA_NS_PER_SEC}) begin
            n = n - {1'b0, `PTCA_NS_PER_SEC};
            tadd.sec = t.sec + 32'h1;
        end
        tadd.ns = n[31:0];
    endfunction

    // Sample the clock, let n edges pass, expect a gain of d ns
    task automatic run(input string what, input int n, input logic [31:0] d);
        t0 = now;
        cyc(n);
        chk(what, now, tadd(t0, d));
    endtask

    // Read monitor, samples mid-cycle where the answer is settled
    always @(negedge CLK_IN) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("spare read answer", 1, 0);
            else
                chk("read data", rd_data, exp_q.pop_front());
        end
    end

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #400000;
        mismatches++;
        stop_test();
    end

    // Main sequence
    initial begin
        void'($urandom(75892));
        repeat (8) @(posedge CLK_IN);
        #1;
        RST_IN = 1'b0;
        cyc(1);
        // Reset values, one unmapped place at the end
        chk("time after reset", now, '0);
        for (int a = 16'h0500; a <= 16'h0514; a += 2)
            rd(a[15:0], `PTCA_RESET_WORD);
        $display("test reset values done");
        // Register access: phase codes, reserved bits, random words
        // only valid phase codes
        for (int p = 0; p <= 4; p++) begin
            wrt(`PTCA_OFF_PHASE, 16'hFFF8 | p[15:0]);
            rd(`PTCA_OFF_PHASE, p[15:0]);
        end
        for (int a = 16'h0504; a <= 16'h0512; a += 2) begin
            v = 16'($urandom());
            if (a == 16'h050C)
                v[14] = 1'b0;
            wrt(a[15:0], v);
            rd(a[15:0], v);
        end
        wrt(`PTCA_OFF_CTRL, 16'hFFA4);
        rd(`PTCA_OFF_CTRL, 16'h8024);
        $display("test register access done");
        // Load while stopped, then run
        rs = $urandom() % 32'h7FFFFFFF;
        rn = $urandom() % 32'd1000000000;
        hold(rs, rn, 3'h4);
        wrt(`PTCA_OFF_CTRL, 16'h0008);
        chk("loaded phase", now.phase, 3'h4);
        chk("loaded time", now, {rs, rn, 3'h4});
        run("stopped clock", 10, 0);
        wrt(`PTCA_OFF_CTRL, 16'h0002);
        run("running clock", 25, 1000);
        // Snapshot takes the value before the write edge
        t0 = now;
        acc(1'b1, 1'b0, `PTCA_OFF_CTRL, 16'h0012);
        rd(`PTCA_OFF_NS_HI, t0.ns[31:16]);
        rd(`PTCA_OFF_NS_LO, t0.ns[15:0]);
        rd(`PTCA_OFF_SEC_HI, t0.sec[31:16]);
        rd(`PTCA_OFF_SEC_LO, t0.sec[15:0]);
        rd(`PTCA_OFF_PHASE, {13'h0000, t0.phase});
        rd(`PTCA_OFF_CTRL, 16'h0002);
        $display("test load run snapshot done");
        // Wrap at one second
        hold(32'h5, 32'd999999900, 3'h0);
        wrt(`PTCA_OFF_CTRL, 16'h000A);
        run("second wrap", 5, 200);
        // Self-clearing reset
        wrt(`PTCA_OFF_CTRL, 16'h0001);
        chk("time after reset bit", now, '0);
        rd(`PTCA_OFF_CTRL, 16'h0000);
        // Step forward then back with a borrowed second
        hold(32'd10, 32'd900000000, 3'h0);
        wrt(`PTCA_OFF_CTRL, 16'h0008);
        hold(32'd1, 32'd200000000, 3'h0);
        wrt(`PTCA_OFF_CTRL, 16'h0060);
        chk("step add", now, {32'd12, 32'd100000000, 3'h0});
        wrt(`PTCA_OFF_CTRL, 16'h0040);
        chk("step sub", now, {32'd10, 32'd900000000, 3'h0});
        $display("test wrap reset step done");
        // Continuous trim of half a nanosecond per tick
        hold(32'h0, 32'h0, 3'h0);
        wrt(`PTCA_OFF_CTRL, 16'h000A);
        wrt(`PTCA_OFF_RATE_LO, 16'h0000);
        wrt(`PTCA_OFF_RATE_HI, 16'hA000);
        wrt(`PTCA_OFF_CTRL, 16'h0006);
        run("trim add", 20, 810);
        wrt(`PTCA_OFF_RATE_HI, 16'h2000);
        run("trim sub", 20, 790);
        wrt(`PTCA_OFF_CTRL, 16'h0002);
        // Temporary trim over ten ticks
        wrt(`PTCA_OFF_DUR_HI, 16'h0000);
        wrt(`PTCA_OFF_DUR_LO, 16'h000A);
        wrt(`PTCA_OFF_CTRL, 16'h000A);
        t0 = now;
        wrt(`PTCA_OFF_RATE_HI, 16'hE000);
        chk("trim active", adj, 1'b1);
        cyc(20);
        chk("temporary trim", now, tadd(t0, 32'd885));
        chk("trim ended", adj, 1'b0);
        rd(`PTCA_OFF_RATE_HI, 16'hA000);
        // Clearing the temporary bit stops the trim
        wrt(`PTCA_OFF_DUR_LO, 16'h03E8);
        wrt(`PTCA_OFF_RATE_HI, 16'h6000);
        cyc(3);
        chk("long trim active", adj, 1'b1);
        wrt(`PTCA_OFF_RATE_HI, 16'hA000);
        chk("trim stopped", adj, 1'b0);
        run("no trim after stop", 10, 400);
        $display("test rate trim done");
        cyc(4);
        chk("reads answered", exp_q.size(), 0);
        stop_test();
    end
endmodule
